// [core/ars_supervisor.v]
// Phase supervisor of the axis ring module: phases, errors, status and display.
// Notes on behaviour
// - Command and actual values are exchanged once per strictly equidistant cycle.
// - After one faulty transfer the last valid values are kept for that cycle.
// - After two faulty transfers in a row all drives are switched off.
// - At most eight drives are served, each addressed by one bit of an eight-bit axis field.
// - After power-on a self-check runs and any fault is shown on the status display.
// - A system error latches its code and presents 0x4000 as interrupt status.
// - A system error forces phase 0 and, once cleared, a new phase build-up starts by itself.
// - An axis error sets that axis's diagnostic bit and presents 0x01 plus the axis bit, unless a system error is raised in the same cycle.
// - Some axis errors additionally raise a system error.
// - After an axis error the phase is held until the host clears the axis error.
// - Supervisor state is E001..E004 in phases 0..3, E011..E014 while switching, E005 in phase 4.
// - Supervisor state is E006 or E007 in the test modes, E008 for an open ring and 0000 in reset.
// - In a test mode the test pattern is sent and no new phase switch starts; a switch already under way completes.
// - Without ten consecutive sync telegrams in phase 0 after reset the ring is open.
`timescale 1ns/1ps
`include "ars_map.vh"
module ars_supervisor #(
  parameter NAX = 8,
  parameter DW = 16,
  parameter CYCLE_TICKS = 1000,
  parameter SYNC_WAIT = 100
) (
  // Clock and reset.
  input wire i_clk_sys,
  input wire i_rst_n,
  // Ring receive side.
  input wire i_master_sync_telegram,
  input wire i_rx_valid,
  input wire i_rx_fault,
  input wire [NAX*DW-1:0] i_rx_actual,
  // Host side.
  input wire [NAX*DW-1:0] i_cmd_values,
  input wire i_sys_err,
  input wire [15:0] i_sys_err_code,
  input wire i_sys_err_clear,
  input wire [NAX-1:0] i_axis_err,
  input wire [NAX-1:0] i_axis_err_fatal,
  input wire i_axis_err_clear,
  input wire i_phase_up_req,
  input wire i_selftest_fail,
  input wire i_test_zero_bits,
  input wire i_test_steady,
  // Ring transmit side.
  output reg o_cycle_start,
  output reg [NAX*DW-1:0] o_tx_cmd,
  output reg [1:0] o_tx_pattern,
  // Drive and host status.
  output reg [NAX*DW-1:0] o_actual,
  output reg [NAX-1:0] o_drive_enable,
  output reg [NAX-1:0] o_axis_diag,
  output reg [15:0] o_irq_status,
  output reg [15:0] o_sys_err_param,
  output reg [15:0] o_supervisor_state,
  output reg [2:0] o_phase,
  output reg [6:0] o_seg
);
  // =====================================================================
  // Reset release through two flip-flops.
  reg rst_s1_r;
  reg rst_s2_r;
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  wire rst_n = rst_s2_r;

  // =====================================================================
  // Cycle timer.
  localparam [2:0] S_SELF = 3'h0, S_SYNC = 3'h1, S_PHASE = 3'h2, S_SWITCH = 3'h3;
  localparam [2:0] S_OPEN = 3'h4, S_FAIL = 3'h5;
  reg [2:0] st_r;
  wire tick;
  wire run = (st_r == S_PHASE) || (st_r == S_SWITCH) || (st_r == S_SYNC);
  ars_cycle_timer #(.CYCLE_TICKS(CYCLE_TICKS), .CW(32)) u_timer (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(rst_n),
    .i_run(run),
    .o_cycle_tick(tick)
  );

  // =====================================================================
  // Phase sequencer.
  reg [2:0] phase_r;
  reg [7:0] cnt_r;
  reg [31:0] wait_r;
  reg [3:0] sync_r;
  reg sys_err_r;
  reg axis_hold_r;
  reg up_pend_r;
  wire test_on = i_test_zero_bits | i_test_steady;
  wire sys_evt = i_sys_err | (|(i_axis_err & i_axis_err_fatal));
  always @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= S_SELF;
      phase_r <= `ARS_PHASE_0;
      cnt_r <= 8'h00;
      wait_r <= 32'h0;
      sync_r <= 4'h0;
      sys_err_r <= 1'b0;
      axis_hold_r <= 1'b0;
      up_pend_r <= 1'b0;
      o_sys_err_param <= 16'h0000;
    end else begin
      // Set wins over clear on both error flags.
      if (sys_evt) begin
        sys_err_r <= 1'b1;
        o_sys_err_param <= i_sys_err ? i_sys_err_code : o_sys_err_param;
      end else if (i_sys_err_clear) begin
        sys_err_r <= 1'b0;
      end
      if (|i_axis_err) begin
        axis_hold_r <= 1'b1;
      end else if (i_axis_err_clear) begin
        axis_hold_r <= 1'b0;
      end
      if (i_phase_up_req) begin
        up_pend_r <= 1'b1;
      end
      case (st_r)
        S_SELF: begin
          cnt_r <= cnt_r + 8'h01;
          if (i_selftest_fail) begin
            st_r <= S_FAIL;
          end else if (cnt_r == `ARS_SELFTEST_CYCLES) begin
            st_r <= S_SYNC;
            wait_r <= 32'h0;
            sync_r <= 4'h0;
          end
        end
        S_SYNC: begin
          wait_r <= wait_r + 32'h1;
          if (i_master_sync_telegram) begin
            sync_r <= i_rx_fault ? 4'h0 : sync_r + 4'h1;
          end
          if (sync_r == `ARS_SYNC_RUN) begin
            st_r <= S_PHASE;
          end else if (wait_r == SYNC_WAIT) begin
            st_r <= S_OPEN;
          end
        end
        S_PHASE: begin
          cnt_r <= 8'h00;
          if (sys_evt || sys_err_r) begin
            phase_r <= `ARS_PHASE_0;
          end else if (!test_on && phase_r != `ARS_PHASE_4 && !axis_hold_r) begin
            if (phase_r == `ARS_PHASE_0 || up_pend_r) begin
              st_r <= S_SWITCH;
              up_pend_r <= 1'b0;
            end
          end
        end
        S_SWITCH: begin
          if (sys_evt) begin
            st_r <= S_PHASE;
            phase_r <= `ARS_PHASE_0;
          end else if ((|i_axis_err) || axis_hold_r) begin
            // An axis error aborts the pending switch, so the phase stays where it is.
            st_r <= S_PHASE;
          end else if (tick) begin
            cnt_r <= cnt_r + 8'h01;
            if (cnt_r == `ARS_SWITCH_CYCLES) begin
              phase_r <= phase_r + 3'h1;
              st_r <= S_PHASE;
            end
          end
        end
        S_FAIL: st_r <= S_FAIL;
        S_OPEN: st_r <= S_OPEN;
        default: st_r <= S_SELF;
      endcase
    end
  end

  // =====================================================================
  // Cyclic exchange with one fault count shared by all axes.
  reg [NAX-1:0] bad_once_r;
  reg drives_off_r;
  wire second_bad = i_rx_valid && i_rx_fault && (&bad_once_r);
  integer k;
  always @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      o_cycle_start <= 1'b0;
      o_tx_cmd <= {NAX*DW{1'b0}};
      o_actual <= {NAX*DW{1'b0}};
      o_drive_enable <= {NAX{1'b0}};
      bad_once_r <= {NAX{1'b0}};
      drives_off_r <= 1'b0;
      o_axis_diag <= {NAX{1'b0}};
    end else begin
      o_cycle_start <= tick;
      if (tick) begin
        o_tx_cmd <= i_cmd_values;
      end
      if (i_rx_valid && !i_rx_fault) begin
        o_actual <= i_rx_actual;
        bad_once_r <= {NAX{1'b0}};
      end else if (i_rx_valid) begin
        bad_once_r <= {NAX{1'b1}};
      end
      // The switch-off latches until the phase drops, so a later good cycle cannot re-enable the drives.
      if (second_bad) begin
        drives_off_r <= 1'b1;
      end else if (phase_r != `ARS_PHASE_4) begin
        drives_off_r <= 1'b0;
      end
      if (st_r == S_PHASE && phase_r == `ARS_PHASE_4 && !drives_off_r && !second_bad) begin
        o_drive_enable <= {NAX{1'b1}};
      end else if (phase_r != `ARS_PHASE_4 || drives_off_r || second_bad) begin
        o_drive_enable <= {NAX{1'b0}};
      end
      for (k = 0; k < NAX; k = k + 1) begin
        if (i_axis_err[k]) begin
          o_axis_diag[k] <= 1'b1;
        end else if (i_axis_err_clear) begin
          o_axis_diag[k] <= 1'b0;
        end
      end
    end
  end

  // =====================================================================
  // Interrupt status, supervisor state and display.
  always @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      o_irq_status <= `ARS_IRQ_NONE;
      o_supervisor_state <= `ARS_ST_RESET;
      o_seg <= `ARS_SEG_8;
      o_tx_pattern <= 2'h0;
      o_phase <= `ARS_PHASE_0;
    end else begin
      o_phase <= phase_r;
      o_tx_pattern <= i_test_zero_bits ? 2'h1 : (i_test_steady ? 2'h2 : 2'h0);
      if (sys_evt) begin
        o_irq_status <= `ARS_IRQ_SYSTEM;
      end else if (|i_axis_err) begin
        o_irq_status <= {`ARS_IRQ_AXIS_HI, i_axis_err};
      end else if (i_sys_err_clear || i_axis_err_clear) begin
        o_irq_status <= `ARS_IRQ_NONE;
      end
      if (st_r == S_FAIL) begin
        o_supervisor_state <= `ARS_ST_RESET;
        o_seg <= `ARS_SEG_E;
      end else if (st_r == S_OPEN) begin
        o_supervisor_state <= `ARS_ST_RING_OPEN;
        o_seg <= `ARS_SEG_7;
      end else if (i_test_zero_bits) begin
        o_supervisor_state <= `ARS_ST_ZERO_BITS;
        o_seg <= `ARS_SEG_5;
      end else if (i_test_steady) begin
        o_supervisor_state <= `ARS_ST_STEADY;
        o_seg <= `ARS_SEG_6;
      end else if (st_r == S_SELF) begin
        o_supervisor_state <= `ARS_ST_RESET;
        o_seg <= `ARS_SEG_8;
      end else if (phase_r == `ARS_PHASE_4) begin
        o_supervisor_state <= `ARS_ST_READY;
        o_seg <= `ARS_SEG_B;
      end else begin
        o_supervisor_state <= ((st_r == S_SWITCH) ? `ARS_ST_SWITCH_BASE : `ARS_ST_PHASE_BASE)
                              + {13'h0, phase_r};
        case (phase_r)
          3'h1: o_seg <= `ARS_SEG_1;
          3'h2: o_seg <= `ARS_SEG_2;
          3'h3: o_seg <= `ARS_SEG_3;
          default: o_seg <= `ARS_SEG_0;
        endcase
      end
    end
  end
endmodule // ars_supervisor

// [core/ars_map.vh]
// Constant map of the axis ring phase supervisor.
`ifndef ARS_MAP_VH
`define ARS_MAP_VH
// Supervisor state codes.
`define ARS_ST_RESET 16'h0000
`define ARS_ST_PHASE_BASE 16'he001
`define ARS_ST_SWITCH_BASE 16'he011
`define ARS_ST_READY 16'he005
`define ARS_ST_ZERO_BITS 16'he006
`define ARS_ST_STEADY 16'he007
`define ARS_ST_RING_OPEN 16'he008
// Interrupt status codes.
`define ARS_IRQ_NONE 16'h0000
`define ARS_IRQ_SYSTEM 16'h4000
`define ARS_IRQ_AXIS_HI 8'h01
// Seven-segment codes (segments g..a, active high).
`define ARS_SEG_0 7'h3f
`define ARS_SEG_1 7'h06
`define ARS_SEG_2 7'h5b
`define ARS_SEG_3 7'h4f
`define ARS_SEG_B 7'h7c
`define ARS_SEG_5 7'h6d
`define ARS_SEG_6 7'h7d
`define ARS_SEG_7 7'h07
`define ARS_SEG_8 7'h7f
`define ARS_SEG_E 7'h79
// Phase numbers and counts.
`define ARS_PHASE_0 3'h0
`define ARS_PHASE_4 3'h4
`define ARS_SYNC_RUN 4'ha
`define ARS_SELFTEST_CYCLES 8'h10
`define ARS_SWITCH_CYCLES 8'h08
`endif

// [core/ars_cycle_timer.v]
// Equidistant communication cycle timer of the axis ring phase supervisor.
`timescale 1ns/1ps
module ars_cycle_timer #(
  parameter CYCLE_TICKS = 1000,
  parameter CW = 16
) (
  // Clock and reset.
  input wire i_clk_sys,
  input wire i_rst_n,
  // Cycle strobe.
  input wire i_run,
  output reg o_cycle_tick
);
  // =====================================================================
  // Free-running divider; restarting only on i_run keeps periods exact.
  // The terminal count is cut to the counter width on purpose.
  localparam [31:0] LAST_FULL = CYCLE_TICKS - 1;
  localparam [CW-1:0] LAST_TICK = LAST_FULL[CW-1:0];
  reg [CW-1:0] cnt_r;
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_r <= {CW{1'b0}};
      o_cycle_tick <= 1'b0;
    end else if (!i_run) begin
      cnt_r <= {CW{1'b0}};
      o_cycle_tick <= 1'b0;
    end else if (cnt_r == LAST_TICK) begin
      cnt_r <= {CW{1'b0}};
      o_cycle_tick <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 1'b1;
      o_cycle_tick <= 1'b0;
    end
  end
endmodule // ars_cycle_timer

// [test/ars_sup_sva.sv]
// Port assertions of the axis ring phase supervisor.
`timescale 1ns/1ps
// =====
// Checker.
module ars_sup_sva (
  input wire i_clk_sys,
  input wire i_rst_n,
  input wire i_rx_valid,
  input wire i_rx_fault,
  input wire i_sys_err,
  input wire [15:0] i_sys_err_code,
  input wire [7:0] i_axis_err,
  input wire [7:0] i_axis_err_fatal,
  input wire i_phase_up_req,
  input wire i_test_zero_bits,
  input wire i_test_steady,
  input wire o_cycle_start,
  input wire [127:0] o_actual,
  input wire [1:0] o_tx_pattern,
  input wire [7:0] o_drive_enable,
  input wire [7:0] o_axis_diag,
  input wire [15:0] o_irq_status,
  input wire [15:0] o_sys_err_param,
  input wire [15:0] o_supervisor_state,
  input wire [2:0] o_phase
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  reg fault_prev_r;
  wire live = o_supervisor_state != 16'h0000;
  // Remembers whether the last transfer was faulty, so a second one can be seen.
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) fault_prev_r <= 1'b0;
    else if (i_rx_valid) fault_prev_r <= i_rx_fault;
  end
  sequence s_sys;
    i_sys_err && live;
  endsequence
  sequence s_two;
    i_rx_valid && i_rx_fault && fault_prev_r;
  endsequence
  sequence s_axis;
    (|i_axis_err) && !(|i_axis_err_fatal) && !i_sys_err && !i_phase_up_req && live;
  endsequence
  AST_SYS_IRQ: assert property (s_sys |=> o_irq_status == 16'h4000 ##1 o_phase == 3'h0)
    else $error("system error not reported");
  AST_SYS_PARAM: assert property (s_sys |=> o_sys_err_param == $past(i_sys_err_code))
    else $error("system error code not latched");
  AST_AXIS: assert property (s_axis |=> o_irq_status[15:8] == 8'h01 && (o_axis_diag & $past(i_axis_err)) != 0)
    else $error("axis error not reported");
  AST_HOLD: assert property (s_axis |-> ##2 $stable(o_phase))
    else $error("phase moved on axis error");
  AST_STEP: assert property (o_phase != $past(o_phase) |-> o_phase == 3'h0 || o_phase == $past(o_phase) + 3'h1)
    else $error("phase skipped");
  AST_READY: assert property (o_phase == 3'h4 && !$past(i_test_zero_bits) && !$past(i_test_steady)
    |-> o_supervisor_state == 16'he005)
    else $error("phase four without ready code");
  AST_CODE: assert property (o_supervisor_state[15:5] == 11'h700 && o_supervisor_state[3:0] != 0 &&
    o_supervisor_state[3:0] < 5 |-> o_supervisor_state[3:0] == {1'b0, o_phase} + 4'h1)
    else $error("state code does not match phase");
  AST_TEST: assert property (i_test_zero_bits && !i_test_steady && live |=> o_tx_pattern == 2'h1)
    else $error("zero bit pattern missing");
  AST_KEEP: assert property (i_rx_valid && i_rx_fault |=> $stable(o_actual))
    else $error("faulty values applied");
  AST_OFF: assert property (s_two |=> o_drive_enable == 8'h00)
    else $error("drives not switched off");
  // The bench runs a four clock cycle, so three quiet clocks follow each start.
  AST_CYC: assert property (o_cycle_start |=> !o_cycle_start [*3])
    else $error("cycle start too early");
endmodule // ars_sup_sva
bind ars_supervisor ars_sup_sva i_ars_sup_sva (.*);

// [test/ars_drive_model.sv]
// Behavioural model of the drives on the fibre-optic ring.
`timescale 1ns/1ps
module ars_drive_model (
  // Clock and controls.
  input wire i_clk_sys,
  input wire i_cycle_start,
  input wire i_sync_on,
  input wire i_fault,
  // Receive side of the supervisor.
  output reg o_master_sync_telegram,
  output reg o_rx_valid,
  output reg o_rx_fault,
  output reg [127:0] o_rx_actual
);
  reg [2:0] div_r = 3'h0;
  reg [15:0] cnt_r = 16'h0000;
  initial {o_master_sync_telegram, o_rx_valid, o_rx_fault, o_rx_actual} = 0;
  // One answer per cycle start; between answers the data lines churn so stale values are never trusted.
  always @(posedge i_clk_sys) begin
    div_r <= div_r + 3'h1;
    o_master_sync_telegram <= i_sync_on && div_r == 3'h0;
    o_rx_valid <= i_cycle_start;
    o_rx_fault <= i_cycle_start && i_fault;
    if (i_cycle_start) cnt_r <= cnt_r + 16'h0101;
    o_rx_actual <= i_cycle_start ? {8{cnt_r}} : ~o_rx_actual;
  end
endmodule // ars_drive_model

// [test/testbench.sv]
// Self-checking testbench of the axis ring phase supervisor.
`timescale 1ns/1ps
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin err_count++; \
  $display("unexpected %s exp %h got %h", n, e, a); end end
module testbench;
  reg clk = 0, rst_n = 0, sync_on = 1, fault = 0, sys_err = 0, sys_clr = 0, axis_clr = 0, up = 0;
  reg st_fail = 0, tz = 0, ts = 0;
  reg [15:0] code = 16'h0000;
  reg [7:0] axis_err = 8'h00;
  reg [7:0] fatal = 8'h00;
  wire [127:0] cmd = {8{16'h1234}};
  wire cs, master_sync_telegram, rxv, rxf;
  wire [127:0] rxa, act, txc;
  wire [1:0] pat;
  wire [7:0] den, diag;
  wire [15:0] irq, sep, st;
  wire [2:0] ph;
  wire [6:0] seg;
  int err_count = 0, num_checks = 0;
  // ==========
  // Design, drive model and clock.
  ars_supervisor #(.CYCLE_TICKS(4), .SYNC_WAIT(100)) i_ars_supervisor (.i_clk_sys(clk), .i_rst_n(rst_n),
    .i_master_sync_telegram(master_sync_telegram), .i_rx_valid(rxv), .i_rx_fault(rxf), .i_rx_actual(rxa),
    .i_cmd_values(cmd), .i_sys_err(sys_err), .i_sys_err_code(code), .i_sys_err_clear(sys_clr),
    .i_axis_err(axis_err), .i_axis_err_fatal(fatal), .i_axis_err_clear(axis_clr), .i_phase_up_req(up),
    .i_selftest_fail(st_fail), .i_test_zero_bits(tz), .i_test_steady(ts), .o_cycle_start(cs), .o_tx_cmd(txc),
    .o_tx_pattern(pat), .o_actual(act), .o_drive_enable(den), .o_axis_diag(diag), .o_irq_status(irq),
    .o_sys_err_param(sep), .o_supervisor_state(st), .o_phase(ph), .o_seg(seg));
  ars_drive_model i_ars_drive_model (.i_clk_sys(clk), .i_cycle_start(cs), .i_sync_on(sync_on), .i_fault(fault),
    .o_master_sync_telegram(master_sync_telegram), .o_rx_valid(rxv), .o_rx_fault(rxf), .o_rx_actual(rxa));
  initial forever #5 clk = ~clk;
  task tick(input int n); repeat (n) @(negedge clk); endtask
  // Waits are bounded so a stuck design shows up as a mismatch.
  task wait_st(input [15:0] s); int k; k = 0; while (st !== s && k < 3000) begin tick(1); k++; end endtask
  task wait_rx; int k; k = 0; tick(1); while (!(rxv && rxf) && k < 100) begin tick(1); k++; end endtask
  task do_reset; @(posedge clk) rst_n <= 0; repeat (8) @(posedge clk);
    `CHK("reset state", 16'h0000, st)
    rst_n <= 1; endtask
  task pulse_up; @(posedge clk) up <= 1; @(posedge clk) up <= 0; endtask
  task t_start; do_reset; wait_st(16'he011);
    `CHK("switching", 16'he011, st)
    wait_st(16'he002);
    `CHK("phase", 3'h1, ph)
  endtask
  task t_steps; for (int p = 1; p < 4; p++) begin
    pulse_up; wait_st(16'he011 + p);
    `CHK("switching", 16'he011 + p, st)
    wait_st(16'he002 + p);
    `CHK("phase", p + 1, ph)
  end
    `CHK("drives", 8'hff, den)
    `CHK("command", cmd, txc)
  endtask
  task t_axis; @(posedge clk) axis_err <= 8'h08; @(posedge clk) axis_err <= 8'h00; tick(2);
    `CHK("irq", 16'h0108, irq)
    `CHK("diag", 8'h08, diag)
    @(posedge clk) axis_clr <= 1; @(posedge clk) axis_clr <= 0; tick(20);
    `CHK("diag clr", 8'h00, diag)
    `CHK("held", 3'h4, ph)
  endtask
  task t_fault; reg [127:0] a; @(posedge clk) fault <= 1; wait_rx; a = act; tick(2);
    `CHK("kept", a, act)
    `CHK("one fault", 8'hff, den)
    wait_rx; tick(2);
    `CHK("two faults", 8'h00, den)
    @(posedge clk) fault <= 0; endtask
  task t_sys; @(posedge clk) begin code <= 16'hf003; sys_err <= 1; end @(posedge clk) sys_err <= 0; tick(2);
    `CHK("irq", 16'h4000, irq)
    `CHK("param", 16'hf003, sep)
    `CHK("phase", 3'h0, ph)
    @(posedge clk) sys_clr <= 1; @(posedge clk) sys_clr <= 0; wait_st(16'he002);
    `CHK("rebuilt", 3'h1, ph)
    @(posedge clk) begin axis_err <= 8'h02; fatal <= 8'h02; end
    @(posedge clk) begin axis_err <= 8'h00; fatal <= 8'h00; end
    tick(2);
    `CHK("fatal irq", 16'h4000, irq)
    `CHK("fatal phase", 3'h0, ph)
    @(posedge clk) begin sys_clr <= 1; axis_clr <= 1; end
    @(posedge clk) begin sys_clr <= 0; axis_clr <= 0; end
    wait_st(16'he002);
  endtask
  task t_test; @(posedge clk) tz <= 1; tick(3);
    `CHK("zero state", 16'he006, st)
    `CHK("zero pat", 2'h1, pat)
    pulse_up; tick(50);
    `CHK("no build-up", 3'h1, ph)
    @(posedge clk) begin tz <= 0; ts <= 1; end tick(3);
    `CHK("steady state", 16'he007, st)
    `CHK("steady pat", 2'h2, pat)
    @(posedge clk) ts <= 0; endtask
  task t_open; @(posedge clk) sync_on <= 0; do_reset; tick(200);
    `CHK("open", 16'he008, st)
  endtask
  task t_self; @(posedge clk) begin sync_on <= 1; st_fail <= 1; end do_reset; tick(30);
    `CHK("seg", 7'h79, seg)
  endtask
  task results; $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish; endtask
  // Main sequence and watchdog.
  initial begin t_start; t_steps; t_axis; t_fault; t_sys; t_test; t_open; t_self; results; end
  initial begin #300000; err_count++; results; end
endmodule // testbench
